// >>> logic/probe_pkg.sv
//
// Contract
// [R1] Mode bit 9 (probe two) or 1 (probe three) picks single capture when 0, continuous when 1.
// [R2] Probe two source bit 10 picks the input when 0, the encoder zero point when 1.
// [R3] Probe two rising bit 12 with the input as source stores position and time stamp on a rise.
// [R4] Probe two falling bit 13 with the input as source stores position and time stamp on a fall.
// [R5] With the zero point as source, passing it stores position only, per enabled edge.
// [R6] Probe three control bit 0 disables probe three when 0, enables it when 1.
// [R7] Probe three source bit 2 picks the input when 0, the encoder zero point when 1.
// [R8] Probe three rising bit 4 stores position on a rise, plus the time stamp from the input.
// [R9] Probe three falling bit 5 stores position on a fall, plus the time stamp from the input.
// [R10] Reserved control bits read back undefined; software writes them zero.
// [R11] Linear zero points lie every homing stop interval from the linear home position.
// [R12] First control word bit 8 disables probe two when 0, enables it when 1.
// [R13] A stored flag sets on each capture and clears while its sampling bit is zero.
// [R14] In continuous mode each edge's toggle bit inverts on every capture of that edge.
// [R15] Single mode latches only the first qualifying edge until the sampling bit is rewritten.
// [R16] A disabled channel latches nothing and keeps its position and time stamp registers.
`default_nettype none

package probe_pkg;
   // apb map, byte addresses
   localparam logic [15:0] OFS_CTRL     = 16'h2de0;
   localparam logic [15:0] OFS_CTRL3    = 16'h2de8;
   localparam logic [15:0] OFS_STATUS   = 16'h2dec;
   localparam logic [15:0] OFS_POS2_R   = 16'h2e00;
   localparam logic [15:0] OFS_POS2_F   = 16'h2e04;
   localparam logic [15:0] OFS_TS2_R    = 16'h2e08;
   localparam logic [15:0] OFS_TS2_F    = 16'h2e0c;
   localparam logic [15:0] OFS_POS3_R   = 16'h2e10;
   localparam logic [15:0] OFS_POS3_F   = 16'h2e14;
   localparam logic [15:0] OFS_TS3_R    = 16'h2e18;
   localparam logic [15:0] OFS_TS3_F    = 16'h2e1c;
   localparam logic [15:0] OFS_IRQ_ST   = 16'h2e20;
   localparam logic [15:0] OFS_IRQ_MASK = 16'h2e24;
   localparam logic [15:0] OFS_CFG      = 16'h2e28;
   localparam logic [15:0] OFS_INTERVAL = 16'h2e2c;
   localparam logic [15:0] OFS_HOME     = 16'h2e30;

   // probe two fields of the first control word
   localparam int unsigned P2_EN_BIT   = 8;
   localparam int unsigned P2_CONT_BIT = 9;
   localparam int unsigned P2_SRC_BIT  = 10;
   localparam int unsigned P2_RISE_BIT = 12;
   localparam int unsigned P2_FALL_BIT = 13;
   // probe three fields of its control word
   localparam int unsigned P3_EN_BIT   = 0;
   localparam int unsigned P3_CONT_BIT = 1;
   localparam int unsigned P3_SRC_BIT  = 2;
   localparam int unsigned P3_RISE_BIT = 4;
   localparam int unsigned P3_FALL_BIT = 5;

   // status word: probe three low byte, probe two high byte
   localparam int unsigned ST2_EN_BIT   = 8;
   localparam int unsigned ST2_RST_BIT  = 9;
   localparam int unsigned ST2_FST_BIT  = 10;
   localparam int unsigned ST2_RTG_BIT  = 14;
   localparam int unsigned ST2_FTG_BIT  = 15;
   localparam int unsigned ST3_EN_BIT   = 0;
   localparam int unsigned ST3_RST_BIT  = 1;
   localparam int unsigned ST3_FST_BIT  = 2;
   localparam int unsigned ST3_RTG_BIT  = 6;
   localparam int unsigned ST3_FTG_BIT  = 7;

   // interrupt status and mask layout
   localparam int unsigned IRQ_W        = 4;
   localparam int unsigned IRQ_P2R_BIT  = 0;
   localparam int unsigned IRQ_P2F_BIT  = 1;
   localparam int unsigned IRQ_P3R_BIT  = 2;
   localparam int unsigned IRQ_P3F_BIT  = 3;
   localparam int unsigned CFG_LIN_BIT  = 0;

   // reset values
   localparam logic [15:0] CTRL_RST     = 16'h0000;
   localparam logic [31:0] INTERVAL_RST = 32'h0000_1000;
   localparam logic [31:0] HOME_RST     = 32'h0000_0000;

   // time stamp runs in ns at the 250 mhz clock
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned TS_STEP_NS   = 1000 / CLK_MHZ;
   localparam int unsigned POS_W        = 32;
endpackage

`default_nettype wire

// >>> logic/probe_latch_chan.sv
`default_nettype none

// one capture channel: edge qualify, latch, stored and toggle flags
module probe_latch_chan #(
   parameter int unsigned POS_W = 32
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             enable_i,
   input  wire logic             cont_i,
   input  wire logic             src_zero_i,
   input  wire logic             rise_en_i,
   input  wire logic             fall_en_i,
   input  wire logic             pin_rise_i,
   input  wire logic             pin_fall_i,
   input  wire logic             zero_i,
   input  wire logic [POS_W-1:0] position_i,
   input  wire logic [31:0]      tstamp_i,
   output logic      [POS_W-1:0] pos_rise_o,
   output logic      [POS_W-1:0] pos_fall_o,
   output logic      [31:0]      ts_rise_o,
   output logic      [31:0]      ts_fall_o,
   output logic                  stored_rise_o,
   output logic                  stored_fall_o,
   output logic                  toggle_rise_o,
   output logic                  toggle_fall_o,
   output logic                  done_rise_o,
   output logic                  done_fall_o
);
   if (POS_W < 8 || POS_W > 32) begin : g_bad_width
      $error("probe_latch_chan: POS_W must lie in 8..32");
   end

   typedef struct packed {
      logic [POS_W-1:0] pos_r;
      logic [POS_W-1:0] pos_f;
      logic [31:0]      ts_r;
      logic [31:0]      ts_f;
      logic             st_r;
      logic             st_f;
      logic             tg_r;
      logic             tg_f;
      logic             dn_r;
      logic             dn_f;
   } chan_s;

   chan_s s_q;
   chan_s s_d;
   logic  trig_r;
   logic  trig_f;
   logic  arm_r;
   logic  arm_f;

   // next state of the channel
   always_comb begin
      s_d = s_q;
      // [R2] [R7] trigger source select
      trig_r = src_zero_i ? zero_i : pin_rise_i;
      trig_f = src_zero_i ? zero_i : pin_fall_i;
      // [R16] [R1] [R15] arm only when enabled; single mode waits for re-arm
      arm_r = enable_i & rise_en_i & (cont_i | ~s_q.st_r);
      arm_f = enable_i & fall_en_i & (cont_i | ~s_q.st_f);
      s_d.dn_r = arm_r & trig_r;
      s_d.dn_f = arm_f & trig_f;
      // [R13] stored flag drops while its sampling bit is zero
      if (!rise_en_i) begin
         s_d.st_r = 1'b0;
      end
      if (!fall_en_i) begin
         s_d.st_f = 1'b0;
      end
      // [R3] [R8] [R5] rising capture, time stamp only from the input
      if (s_d.dn_r) begin
         s_d.pos_r = position_i;
         if (!src_zero_i) begin
            s_d.ts_r = tstamp_i;
         end
         s_d.st_r = 1'b1;
         // [R14] toggle per capture in continuous mode
         if (cont_i) begin
            s_d.tg_r = ~s_q.tg_r;
         end
      end
      // [R4] [R9] [R5] falling capture
      if (s_d.dn_f) begin
         s_d.pos_f = position_i;
         if (!src_zero_i) begin
            s_d.ts_f = tstamp_i;
         end
         s_d.st_f = 1'b1;
         // [R14] toggle per capture in continuous mode
         if (cont_i) begin
            s_d.tg_f = ~s_q.tg_f;
         end
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pos_rise_o    = s_q.pos_r;
   assign pos_fall_o    = s_q.pos_f;
   assign ts_rise_o     = s_q.ts_r;
   assign ts_fall_o     = s_q.ts_f;
   assign stored_rise_o = s_q.st_r;
   assign stored_fall_o = s_q.st_f;
   assign toggle_rise_o = s_q.tg_r;
   assign toggle_fall_o = s_q.tg_f;
   assign done_rise_o   = s_q.dn_r;
   assign done_fall_o   = s_q.dn_f;
endmodule

`default_nettype wire

// >>> logic/probe_position_latch.sv
// Local design decision: the APB slave port.
`default_nettype none

// touch-probe position latch for probes two and three, apb slave
module probe_position_latch (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // probe pins and encoder
   input  wire logic        second_probe_input_i,
   input  wire logic        third_probe_input_i,
   input  wire logic [31:0] position_i,
   input  wire logic        encoder_zero_i,
   // interrupt
   output logic             irq_o
);
   localparam int unsigned PW = probe_pkg::POS_W;

   typedef struct packed {
      logic [15:0]                  ctrl;
      logic [15:0]                  ctrl3;
      logic [probe_pkg::IRQ_W-1:0]  irq_st;
      logic [probe_pkg::IRQ_W-1:0]  irq_mask;
      logic                         linear;
      logic [31:0]                  interval;
      logic [31:0]                  home;
      logic [31:0]                  zone_lo;
      logic                         lin_zero;
      logic [2:0]                   sync2;
      logic [2:0]                   sync3;
      logic [31:0]                  tstamp;
      logic [31:0]                  rdata;
      logic                         err;
   } top_s;

   top_s s_q;
   top_s s_d;

   // channel outputs
   logic [PW-1:0] pos2_r;
   logic [PW-1:0] pos2_f;
   logic [31:0]   ts2_r;
   logic [31:0]   ts2_f;
   logic [PW-1:0] pos3_r;
   logic [PW-1:0] pos3_f;
   logic [31:0]   ts3_r;
   logic [31:0]   ts3_f;
   logic          st2_r;
   logic          st2_f;
   logic          tg2_r;
   logic          tg2_f;
   logic          st3_r;
   logic          st3_f;
   logic          tg3_r;
   logic          tg3_f;
   logic          dn2_r;
   logic          dn2_f;
   logic          dn3_r;
   logic          dn3_f;

   // decoded control fields
   logic          p2_en;
   logic          p3_en;
   logic          zero_ev;
   logic          rise2;
   logic          fall2;
   logic          rise3;
   logic          fall3;
   logic [15:0]   status;
   logic          setup;
   logic          access;
   logic          wr;

   // [R12] probe two enable from the first control word
   assign p2_en = s_q.ctrl[probe_pkg::P2_EN_BIT];
   // [R6] probe three enable from its own control word
   assign p3_en = s_q.ctrl3[probe_pkg::P3_EN_BIT];

   // edges from the second and third sync stages; stage 0 feeds stage 1 only
   assign rise2 = s_q.sync2[1] & ~s_q.sync2[2];
   assign fall2 = ~s_q.sync2[1] & s_q.sync2[2];
   assign rise3 = s_q.sync3[1] & ~s_q.sync3[2];
   assign fall3 = ~s_q.sync3[1] & s_q.sync3[2];

   // [R11] linear motors use the interval grid, rotary the encoder pulse
   assign zero_ev = s_q.linear ? s_q.lin_zero : encoder_zero_i;

   // status word as seen by software
   always_comb begin
      status = 16'h0000;
      status[probe_pkg::ST2_EN_BIT]  = p2_en;
      status[probe_pkg::ST2_RST_BIT] = st2_r;
      status[probe_pkg::ST2_FST_BIT] = st2_f;
      status[probe_pkg::ST2_RTG_BIT] = tg2_r;
      status[probe_pkg::ST2_FTG_BIT] = tg2_f;
      status[probe_pkg::ST3_EN_BIT]  = p3_en;
      status[probe_pkg::ST3_RST_BIT] = st3_r;
      status[probe_pkg::ST3_FST_BIT] = st3_f;
      status[probe_pkg::ST3_RTG_BIT] = tg3_r;
      status[probe_pkg::ST3_FTG_BIT] = tg3_f;
   end

   // apb phases; zero wait states, data ready from setup
   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign wr     = access & pwrite;
   assign pready = access;
   assign pslverr = access & s_q.err;
   assign prdata = s_q.rdata;
   assign irq_o  = |(s_q.irq_st & s_q.irq_mask);

   // next state of registers, tracker, syncs and bus
   always_comb begin
      s_d = s_q;
      s_d.sync2 = {s_q.sync2[1:0], second_probe_input_i};
      s_d.sync3 = {s_q.sync3[1:0], third_probe_input_i};
      s_d.tstamp = s_q.tstamp + 32'(probe_pkg::TS_STEP_NS);

      // [R11] zone tracker steps one interval per crossed zero point
      s_d.lin_zero = 1'b0;
      if (s_q.linear && s_q.interval != 32'h0000_0000) begin
         if ($signed(position_i) >= $signed(s_q.zone_lo + s_q.interval)) begin
            s_d.lin_zero = 1'b1;
            s_d.zone_lo  = s_q.zone_lo + s_q.interval;
         end else if ($signed(position_i) < $signed(s_q.zone_lo)) begin
            s_d.lin_zero = 1'b1;
            s_d.zone_lo  = s_q.zone_lo - s_q.interval;
         end
      end

      // read decode in the setup phase, held through access
      if (setup) begin
         s_d.err = 1'b0;
         case (paddr)
            probe_pkg::OFS_CTRL:     s_d.rdata = {16'h0000, s_q.ctrl};
            probe_pkg::OFS_CTRL3:    s_d.rdata = {16'h0000, s_q.ctrl3};
            probe_pkg::OFS_STATUS:   s_d.rdata = {16'h0000, status};
            probe_pkg::OFS_POS2_R:   s_d.rdata = 32'(pos2_r);
            probe_pkg::OFS_POS2_F:   s_d.rdata = 32'(pos2_f);
            probe_pkg::OFS_TS2_R:    s_d.rdata = ts2_r;
            probe_pkg::OFS_TS2_F:    s_d.rdata = ts2_f;
            probe_pkg::OFS_POS3_R:   s_d.rdata = 32'(pos3_r);
            probe_pkg::OFS_POS3_F:   s_d.rdata = 32'(pos3_f);
            probe_pkg::OFS_TS3_R:    s_d.rdata = ts3_r;
            probe_pkg::OFS_TS3_F:    s_d.rdata = ts3_f;
            probe_pkg::OFS_IRQ_ST:   s_d.rdata = 32'(s_q.irq_st);
            probe_pkg::OFS_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
            probe_pkg::OFS_CFG:      s_d.rdata = {31'h0000_0000, s_q.linear};
            probe_pkg::OFS_INTERVAL: s_d.rdata = s_q.interval;
            probe_pkg::OFS_HOME:     s_d.rdata = s_q.home;
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.err   = 1'b1;
            end
         endcase
      end

      // writes take effect at the access edge; errors change nothing
      if (wr && !s_q.err) begin
         case (paddr)
            // [R10] reserved bits stored as written; software keeps them zero
            probe_pkg::OFS_CTRL:     s_d.ctrl = pwdata[15:0];
            probe_pkg::OFS_CTRL3:    s_d.ctrl3 = pwdata[15:0];
            probe_pkg::OFS_IRQ_MASK: s_d.irq_mask = pwdata[probe_pkg::IRQ_W-1:0];
            probe_pkg::OFS_CFG:      s_d.linear = pwdata[probe_pkg::CFG_LIN_BIT];
            probe_pkg::OFS_INTERVAL: s_d.interval = pwdata;
            probe_pkg::OFS_HOME: begin
               // re-anchor the zero grid on the new home position
               s_d.home    = pwdata;
               s_d.zone_lo = pwdata;
            end
            probe_pkg::OFS_IRQ_ST:   s_d.irq_st = s_q.irq_st & ~pwdata[probe_pkg::IRQ_W-1:0];
            default: begin
               s_d.ctrl = s_q.ctrl;
            end
         endcase
      end

      // capture events set sticky bits after the clear, so set wins
      if (dn2_r) begin
         s_d.irq_st[probe_pkg::IRQ_P2R_BIT] = 1'b1;
      end
      if (dn2_f) begin
         s_d.irq_st[probe_pkg::IRQ_P2F_BIT] = 1'b1;
      end
      if (dn3_r) begin
         s_d.irq_st[probe_pkg::IRQ_P3R_BIT] = 1'b1;
      end
      if (dn3_f) begin
         s_d.irq_st[probe_pkg::IRQ_P3F_BIT] = 1'b1;
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s_q          <= '0;
         s_q.ctrl     <= probe_pkg::CTRL_RST;
         s_q.ctrl3    <= probe_pkg::CTRL_RST;
         s_q.interval <= probe_pkg::INTERVAL_RST;
         s_q.home     <= probe_pkg::HOME_RST;
         s_q.zone_lo  <= probe_pkg::HOME_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // probe two channel, first control word
   probe_latch_chan #(
      .POS_W (PW)
   ) u_chan2 (
      .ref_clk_i     (ref_clk_i),
      .reset_n_i     (reset_n_i),
      .enable_i      (p2_en),
      // [R1] mode bit 9
      .cont_i        (s_q.ctrl[probe_pkg::P2_CONT_BIT]),
      // [R2] source bit 10
      .src_zero_i    (s_q.ctrl[probe_pkg::P2_SRC_BIT]),
      // [R3] rising bit 12
      .rise_en_i     (s_q.ctrl[probe_pkg::P2_RISE_BIT]),
      // [R4] falling bit 13
      .fall_en_i     (s_q.ctrl[probe_pkg::P2_FALL_BIT]),
      .pin_rise_i    (rise2),
      .pin_fall_i    (fall2),
      .zero_i        (zero_ev),
      .position_i    (position_i[PW-1:0]),
      .tstamp_i      (s_q.tstamp),
      .pos_rise_o    (pos2_r),
      .pos_fall_o    (pos2_f),
      .ts_rise_o     (ts2_r),
      .ts_fall_o     (ts2_f),
      .stored_rise_o (st2_r),
      .stored_fall_o (st2_f),
      .toggle_rise_o (tg2_r),
      .toggle_fall_o (tg2_f),
      .done_rise_o   (dn2_r),
      .done_fall_o   (dn2_f)
   );

   // probe three channel, its own control word
   probe_latch_chan #(
      .POS_W (PW)
   ) u_chan3 (
      .ref_clk_i     (ref_clk_i),
      .reset_n_i     (reset_n_i),
      .enable_i      (p3_en),
      // [R1] mode bit 1
      .cont_i        (s_q.ctrl3[probe_pkg::P3_CONT_BIT]),
      // [R7] source bit 2
      .src_zero_i    (s_q.ctrl3[probe_pkg::P3_SRC_BIT]),
      // [R8] rising bit 4
      .rise_en_i     (s_q.ctrl3[probe_pkg::P3_RISE_BIT]),
      // [R9] falling bit 5
      .fall_en_i     (s_q.ctrl3[probe_pkg::P3_FALL_BIT]),
      .pin_rise_i    (rise3),
      .pin_fall_i    (fall3),
      .zero_i        (zero_ev),
      .position_i    (position_i[PW-1:0]),
      .tstamp_i      (s_q.tstamp),
      .pos_rise_o    (pos3_r),
      .pos_fall_o    (pos3_f),
      .ts_rise_o     (ts3_r),
      .ts_fall_o     (ts3_f),
      .stored_rise_o (st3_r),
      .stored_fall_o (st3_f),
      .toggle_rise_o (tg3_r),
      .toggle_fall_o (tg3_f),
      .done_rise_o   (dn3_r),
      .done_fall_o   (dn3_f)
   );
endmodule

`default_nettype wire

// >>> test/probe_checker.sv
`default_nettype none

// apb answer and interrupt level
module probe_checker (
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        second_probe_input_i,
   input wire logic        third_probe_input_i,
   input wire logic [31:0] position_i,
   input wire logic        encoder_zero_i,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic        wr;
   logic        rd;
   logic        act;
   logic [15:0] c2_q;
   logic [15:0] c3_q;
   logic [3:0]  quiet_q;
   logic        p2_q;
   logic        p3_q;
   logic [31:0] pos_q;

   assign wr  = psel && penable && pwrite;
   assign rd  = psel && penable && !pwrite;
   assign act = (second_probe_input_i != p2_q) || (third_probe_input_i != p3_q)
                || encoder_zero_i || (position_i != pos_q);

   // control word mirror
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         c2_q <= 16'h0000;
         c3_q <= 16'h0000;
      end else if (wr && paddr == probe_pkg::OFS_CTRL) begin
         c2_q <= pwdata[15:0];
      end else if (wr && paddr == probe_pkg::OFS_CTRL3) begin
         c3_q <= pwdata[15:0];
      end
   end

   // idle cycles of the far side, saturating
   always_ff @(posedge ref_clk_i) begin
      p2_q  <= second_probe_input_i;
      p3_q  <= third_probe_input_i;
      pos_q <= position_i;
      if (!reset_n_i || act) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
         quiet_q <= quiet_q + 4'h1;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   // zero wait states
   a_ready_now: assert property (pready == (psel && penable))
      else $error("pready wrong");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("stray pslverr");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read data");
   a_rdata_holds: assert property (!$past(psel && !penable) |-> $stable(prdata))
      else $error("prdata moved");
   a_ctrl2_back: assert property (rd && paddr == probe_pkg::OFS_CTRL |-> prdata == {16'h0000, c2_q})
      else $error("ctrl readback");
   a_ctrl3_back: assert property (rd && paddr == probe_pkg::OFS_CTRL3 |-> prdata == {16'h0000, c3_q})
      else $error("ctrl3 readback");
   // irq moves only on activity or a write
   a_irq_rise_cause: assert property ($rose(irq_o) |-> quiet_q <= 4'h5 || $past(wr))
      else $error("irq rose uncaused");
   a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr))
      else $error("irq fell unwritten");
endmodule

`default_nettype wire

// >>> test/probe_partner.sv
`default_nettype none

// sensors and encoder, one cycle behind the bench
module probe_partner (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        pin2_cmd_i,
   input  wire logic        pin3_cmd_i,
   input  wire logic        zero_cmd_i,
   input  wire logic [31:0] pos_cmd_i,
   output logic             second_probe_input_o,
   output logic             third_probe_input_o,
   output logic             encoder_zero_o,
   output logic [31:0]      position_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // changes land just after an edge
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         second_probe_input_o <= 1'h0;
         third_probe_input_o  <= 1'h0;
         encoder_zero_o       <= 1'h0;
         position_o           <= 32'h0;
      end else begin
         second_probe_input_o <= pin2_cmd_i;
         third_probe_input_o  <= pin3_cmd_i;
         encoder_zero_o       <= zero_cmd_i;
         position_o           <= pos_cmd_i;
      end
   end
endmodule

`default_nettype wire

// >>> test/probe_position_latch_tb.sv
`default_nettype none

module probe_position_latch_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk_i = 1'h0;
   logic        reset_n_i = 1'h0;
   logic        psel      = 1'h0;
   logic        penable   = 1'h0;
   logic        pwrite    = 1'h0;
   logic [15:0] paddr     = 16'h0;
   logic [31:0] pwdata    = 32'h0;
   logic [1:0]  pin_c     = 2'h0;
   logic        zero_c    = 1'h0;
   logic [31:0] pos_c     = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq_o;
   logic        pin2;
   logic        pin3;
   logic        zero;
   logic [31:0] pos;
   logic [31:0] rd;
   logic [31:0] t;
   logic        er;
   int          n_fail   = 0;
   int          n_checks = 0;

   always #2 ref_clk_i = ~ref_clk_i;

   probe_partner probe_partner_i (.ref_clk_i, .reset_n_i, .pin2_cmd_i(pin_c[0]),
      .pin3_cmd_i(pin_c[1]), .zero_cmd_i(zero_c), .pos_cmd_i(pos_c),
      .second_probe_input_o(pin2), .third_probe_input_o(pin3),
      .encoder_zero_o(zero), .position_o(pos));

   probe_position_latch probe_position_latch_i (.ref_clk_i, .reset_n_i, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .second_probe_input_i(pin2), .third_probe_input_i(pin3), .position_i(pos),
      .encoder_zero_i(zero), .irq_o);

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // apb transfer plus an idle cycle
   task automatic xfer(logic w, logic [15:0] a, logic [31:0] d);
      int k;
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk_i);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k >= 20) begin
         chk("pready", 32'h0, 32'h1);
         conclude();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk_i);
   endtask

   task automatic wr(logic [15:0] a, logic [31:0] d);
      xfer(1'h1, a, d);
   endtask

   task automatic rx(logic [15:0] a);
      xfer(1'h0, a, 32'h0);
   endtask

   task automatic rc(string n, logic [15:0] a, logic [31:0] e);
      rx(a);
      chk(n, rd, e);
   endtask

   // pin high then low, 12 cycles each
   task automatic pulse(int i);
      pin_c[i] <= 1'h1;
      cyc(12);
      pin_c[i] <= 1'h0;
      cyc(12);
   endtask

   task automatic zpulse();
      zero_c <= 1'h1;
      cyc(1);
      zero_c <= 1'h0;
      cyc(4);
   endtask

   initial begin
      cyc(12);
      reset_n_i <= 1'h1;
      cyc(1);
      // reset values, unmapped address
      rc("ctrl", probe_pkg::OFS_CTRL, 32'h0);
      rc("ctrl3", probe_pkg::OFS_CTRL3, 32'h0);
      rc("interval", probe_pkg::OFS_INTERVAL, probe_pkg::INTERVAL_RST);
      rc("status", probe_pkg::OFS_STATUS, 32'h0);
      rx(16'h2e40);
      chk("unmapped err", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // probe two single capture, irq masked
      wr(probe_pkg::OFS_IRQ_MASK, 32'h0);
      pos_c <= 32'h111;
      wr(probe_pkg::OFS_CTRL, 32'h3100);
      pin_c[0] <= 1'h1;
      cyc(8);
      pos_c <= 32'h222;
      cyc(4);
      pin_c[0] <= 1'h0;
      cyc(8);
      rc("pos2 rise", probe_pkg::OFS_POS2_R, 32'h111);
      rc("pos2 fall", probe_pkg::OFS_POS2_F, 32'h222);
      rx(probe_pkg::OFS_TS2_R);
      t = rd;
      rx(probe_pkg::OFS_TS2_F);
      chk("ts2 span", rd - t, 32'(12 * probe_pkg::TS_STEP_NS));
      rc("status", probe_pkg::OFS_STATUS, 32'h0700);
      rc("irq st", probe_pkg::OFS_IRQ_ST, 32'h3);
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      pos_c <= 32'h333;
      pulse(0);
      rc("pos2 single", probe_pkg::OFS_POS2_R, 32'h111);
      wr(probe_pkg::OFS_IRQ_MASK, 32'hf);
      chk("irq on", {31'h0, irq_o}, 32'h1);
      wr(probe_pkg::OFS_IRQ_ST, 32'h3);
      chk("irq off", {31'h0, irq_o}, 32'h0);
      wr(probe_pkg::OFS_CTRL, 32'h0100);
      rc("status clr", probe_pkg::OFS_STATUS, 32'h0100);
      // continuous capture toggles
      wr(probe_pkg::OFS_CTRL, 32'h1300);
      pos_c <= 32'h444;
      pulse(0);
      rc("status tog", probe_pkg::OFS_STATUS, 32'h4300);
      pos_c <= 32'h555;
      pulse(0);
      rc("pos2 cont", probe_pkg::OFS_POS2_R, 32'h555);
      rc("status tog2", probe_pkg::OFS_STATUS, 32'h0300);
      // disabled probe two keeps its capture
      wr(probe_pkg::OFS_CTRL, 32'h3000);
      pos_c <= 32'h666;
      pulse(0);
      rc("pos2 off", probe_pkg::OFS_POS2_R, 32'h555);
      // probe three on zero point
      wr(probe_pkg::OFS_CTRL3, 32'h35);
      pos_c <= 32'h777;
      zpulse();
      rc("pos3 rise", probe_pkg::OFS_POS3_R, 32'h777);
      rc("pos3 fall", probe_pkg::OFS_POS3_F, 32'h777);
      rc("ts3 none", probe_pkg::OFS_TS3_R, 32'h0);
      rx(probe_pkg::OFS_STATUS);
      chk("status3", rd & 32'hff, 32'h07);
      // probe three, input, falling
      wr(probe_pkg::OFS_CTRL3, 32'h0);
      wr(probe_pkg::OFS_CTRL3, 32'h21);
      pos_c <= 32'h888;
      pulse(1);
      rc("pos3 fall in", probe_pkg::OFS_POS3_F, 32'h888);
      rc("pos3 rise kept", probe_pkg::OFS_POS3_R, 32'h777);
      rx(probe_pkg::OFS_TS3_F);
      chk("ts3 stored", {31'h0, rd != 32'h0}, 32'h1);
      // probe two on zero point
      wr(probe_pkg::OFS_CTRL, 32'h0);
      wr(probe_pkg::OFS_CTRL, 32'h1500);
      pos_c <= 32'h999;
      pulse(0);
      rc("pos2 pin off", probe_pkg::OFS_POS2_R, 32'h555);
      zpulse();
      rc("pos2 zero", probe_pkg::OFS_POS2_R, 32'h999);
      // linear zero grid; the tracker walks one interval a cycle, so settle first
      wr(probe_pkg::OFS_CFG, 32'h1);
      wr(probe_pkg::OFS_INTERVAL, 32'h100);
      pos_c <= 32'h1080;
      cyc(24);
      wr(probe_pkg::OFS_CTRL3, 32'h15);
      pos_c <= 32'h10c0;
      cyc(4);
      rx(probe_pkg::OFS_STATUS);
      chk("lin before", rd & 32'h2, 32'h0);
      pos_c <= 32'h1140;
      cyc(4);
      rx(probe_pkg::OFS_STATUS);
      chk("lin cross", rd & 32'h2, 32'h2);
      conclude();
   end
endmodule

bind probe_position_latch probe_checker probe_checker_i (.ref_clk_i, .reset_n_i, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .second_probe_input_i,
   .third_probe_input_i, .position_i, .encoder_zero_i, .irq_o);

`default_nettype wire
